/* File: rtl/acr_bank.sv */
`timescale 1ns/100ps
`include "acr_defs.svh"
module acr_bank (
  input  wire logic              i_core_clk,
  input  wire logic              i_srst,
  input  wire logic              i_ce,
  input  wire acr_pkg::acr_pins_t i_pins,
  input  wire logic              i_short,
  input  wire logic              i_overtemp,
  output logic                   o_sda_oe_n,
  output acr_pkg::acr_ctrl_t     o_ctrl
);
  import acr_pkg::*;

  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic       scl_reg;
  logic       sda_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
    end else if (i_ce) begin
      scl_sync_reg <= {scl_sync_reg[1:0], i_pins.i_scl};
      sda_sync_reg <= {sda_sync_reg[1:0], i_pins.i_sda};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
    end
  end

  logic scl_new;
  logic sda_new;
  assign scl_new = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
  assign sda_new = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise  = !scl_reg && scl_new;
  assign scl_fall  = scl_reg && !scl_new;
  assign bus_start = scl_reg && scl_new && sda_reg && !sda_new;
  assign bus_stop  = scl_reg && scl_new && !sda_reg && sda_new;

  logic [7:0] regs_reg [1:7];
  acr_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bitcnt_reg;
  logic       rw_reg;
  logic       have_ptr_reg;
  logic       match_reg;
  logic [7:0] ptr_reg;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_now;

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    rd_byte = `ACR_TEST_RDATA;
    if (a >= `ACR_REG_FIRST && a <= `ACR_REG_LAST) begin
      rd_byte = regs_reg[a[2:0]];
    end
  endfunction

  assign wr_stb  = i_ce && scl_fall && state_reg == ACR_RX && bitcnt_reg == 4'h8 && have_ptr_reg;
  assign wr_data = shift_reg;
  assign rd_now  = rd_byte(ptr_reg);

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_reg    <= ACR_IDLE;
      shift_reg    <= 8'h00;
      bitcnt_reg   <= 4'h0;
      rw_reg       <= 1'b0;
      have_ptr_reg <= 1'b0;
      match_reg    <= 1'b0;
      ptr_reg      <= 8'h00;
      o_sda_oe_n   <= 1'b1;
    end else if (i_ce) begin
      if (bus_start) begin
        state_reg    <= ACR_ADDR;
        bitcnt_reg   <= 4'h0;
        have_ptr_reg <= 1'b0;
        o_sda_oe_n   <= 1'b1;
      end else if (bus_stop) begin
        state_reg  <= ACR_IDLE;
        o_sda_oe_n <= 1'b1;
      end else if (scl_rise && (state_reg == ACR_ADDR || state_reg == ACR_RX)) begin
        shift_reg  <= {shift_reg[6:0], sda_reg};
        bitcnt_reg <= bitcnt_reg + 4'h1;
      end else if (scl_rise && state_reg == ACR_TXACK) begin
        if (sda_reg) begin
          state_reg <= ACR_SKIP;
        end
      end else if (scl_fall) begin
        unique case (state_reg)
          ACR_ADDR: begin
            if (bitcnt_reg == 4'h8) begin
              if (shift_reg[7:1] == `ACR_DEV_ADDR) begin
                rw_reg     <= shift_reg[0];
                match_reg  <= 1'b1;
                o_sda_oe_n <= 1'b0;
                state_reg  <= ACR_ACK;
              end else begin
                state_reg <= ACR_SKIP;
              end
            end
          end
          ACR_RX: begin
            if (bitcnt_reg == 4'h8) begin
              o_sda_oe_n <= 1'b0;
              state_reg  <= ACR_ACK;
              if (!have_ptr_reg) begin
                ptr_reg      <= shift_reg;
                have_ptr_reg <= 1'b1;
              end else begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          ACR_ACK: begin
            bitcnt_reg <= 4'h0;
            if (rw_reg && match_reg) begin
              shift_reg  <= rd_now;
              o_sda_oe_n <= rd_now[7];
              state_reg  <= ACR_TX;
            end else begin
              o_sda_oe_n <= 1'b1;
              state_reg  <= ACR_RX;
            end
            match_reg <= 1'b0;
          end
          ACR_TX: begin
            if (bitcnt_reg == 4'h7) begin
              o_sda_oe_n <= 1'b1;
              ptr_reg    <= ptr_reg + 8'h01;
              state_reg  <= ACR_TXACK;
            end else begin
              o_sda_oe_n <= shift_reg[6];
              shift_reg  <= {shift_reg[6:0], 1'b0};
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
          end
          ACR_TXACK: begin
            bitcnt_reg <= 4'h0;
            shift_reg  <= rd_now;
            o_sda_oe_n <= rd_now[7];
            state_reg  <= ACR_TX;
          end
          ACR_IDLE, ACR_SKIP: begin
            o_sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  logic [7:0] therm_cnt_reg;
  logic       therm_evt;
  logic       short_evt;
  logic       short_reg;
  logic       ot_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      short_reg     <= 1'b0;
      ot_reg        <= 1'b0;
      therm_cnt_reg <= 8'h00;
    end else if (i_ce) begin
      short_reg <= i_short;
      ot_reg    <= i_overtemp;
      if (!ot_reg) begin
        therm_cnt_reg <= 8'h00;
      end else if (therm_cnt_reg != 8'(`ACR_DEGLITCH_CYC)) begin
        therm_cnt_reg <= therm_cnt_reg + 8'h01;
      end
    end
  end
  assign therm_evt = therm_cnt_reg == 8'(`ACR_DEGLITCH_CYC);
  assign short_evt = short_reg;

  logic [7:0] func_next;
  always_comb begin
    func_next = regs_reg[1];
    if (wr_stb && ptr_reg == 8'h01) begin
      func_next = (wr_data & `ACR_FUNC_WMASK) | `ACR_FUNC_FIXED;
    end
    if (short_evt) begin
      func_next[`ACR_BIT_FAULT] = 1'b1;
    end
    if (therm_evt) begin
      func_next[`ACR_BIT_THERM] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi <= 7; gi++) begin : g_reg
      localparam logic [7:0] RST = (gi == 1) ? `ACR_RST_FUNC : (gi == 2) ? `ACR_RST_ATTACK :
                                   (gi == 3) ? `ACR_RST_RELEASE : (gi == 4) ? `ACR_RST_HOLD :
                                   (gi == 5) ? `ACR_RST_GAIN : (gi == 6) ? `ACR_RST_LIMGATE :
                                   `ACR_RST_CEILRATIO;
      localparam logic [7:0] MSK = (gi <= 5) ? `ACR_F6_MASK : (gi == 6) ? 8'hff : `ACR_R7_MASK;
      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          regs_reg[gi] <= RST;
        end else if (i_ce) begin
          if (gi == 1) begin
            regs_reg[gi] <= func_next;
          end else if (wr_stb && ptr_reg == 8'(gi)) begin
            regs_reg[gi] <= wr_data & MSK;
          end
        end
      end
    end
  endgenerate

  logic [$clog2(`ACR_RETRY_CYC + 1)-1:0] retry_cnt_reg;
  logic                                  low_duty_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      retry_cnt_reg <= '0;
      low_duty_reg  <= 1'b0;
    end else if (i_ce) begin
      if (short_evt) begin
        low_duty_reg <= 1'b1;
        retry_cnt_reg <= '0;
      end else if (low_duty_reg) begin
        if (retry_cnt_reg == ($bits(retry_cnt_reg))'(`ACR_RETRY_CYC - 1)) begin
          low_duty_reg  <= 1'b0;
          retry_cnt_reg <= '0;
        end else begin
          retry_cnt_reg <= retry_cnt_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_ctrl <= '0;
    end else if (i_ce) begin
      o_ctrl.powered          <= !regs_reg[1][`ACR_BIT_SWS];
      o_ctrl.amp_on           <= regs_reg[1][`ACR_BIT_EN] && !regs_reg[1][`ACR_BIT_SWS]
                                 && !ot_reg && !low_duty_reg;
      o_ctrl.gate_active      <= regs_reg[1][`ACR_BIT_NG]
                                 && regs_reg[7][1:0] != `ACR_RATIO_1TO1;
      o_ctrl.low_duty         <= low_duty_reg;
      o_ctrl.limiter_off      <= regs_reg[6][7];
      o_ctrl.gate_thresh      <= regs_reg[6][6:5];
      o_ctrl.limit_level      <= regs_reg[6][4:0];
      o_ctrl.max_gain         <= regs_reg[7][7:4];
      o_ctrl.ratio            <= regs_reg[7][1:0];
      o_ctrl.attack_interval  <= regs_reg[2][5:0];
      o_ctrl.release_interval <= regs_reg[3][5:0];
      o_ctrl.hold_interval    <= regs_reg[4][5:0];
      o_ctrl.base_gain        <= regs_reg[5][5:0];
    end
  end
endmodule

/* File: rtl/acr_defs.svh */
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_DEV_ADDR        7'h58
`define ACR_REG_FIRST       8'h01
`define ACR_REG_LAST        8'h07
`define ACR_RST_FUNC        8'hc3
`define ACR_RST_ATTACK      8'h05
`define ACR_RST_RELEASE     8'h0b
`define ACR_RST_HOLD        8'h00
`define ACR_RST_GAIN        8'h06
`define ACR_RST_LIMGATE     8'h3a
`define ACR_RST_CEILRATIO   8'hc2
`define ACR_BIT_NG          0
`define ACR_BIT_THERM       2
`define ACR_BIT_FAULT       3
`define ACR_BIT_SWS         5
`define ACR_BIT_EN          6
`define ACR_FUNC_WMASK      8'h6d
`define ACR_FUNC_FIXED      8'h82
`define ACR_F6_MASK         8'h3f
`define ACR_R7_MASK         8'hf3
`define ACR_RATIO_1TO1      2'b00
`define ACR_RETRY_NS        110000
`define ACR_CLK_NS          8
`define ACR_RETRY_CYC       ((`ACR_RETRY_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_DEGLITCH_CYC    8
`define ACR_TEST_RDATA      8'h00
`endif

/* File: rtl/acr_pkg.sv */
package acr_pkg;
  typedef enum logic [2:0] {
    ACR_IDLE, ACR_ADDR, ACR_ACK, ACR_RX, ACR_TX, ACR_TXACK, ACR_SKIP
  } acr_state_t;

  typedef struct packed {
    logic       amp_on;
    logic       powered;
    logic       gate_active;
    logic       low_duty;
    logic       limiter_off;
    logic [1:0] gate_thresh;
    logic [4:0] limit_level;
    logic [3:0] max_gain;
    logic [1:0] ratio;
    logic [5:0] attack_interval;
    logic [5:0] release_interval;
    logic [5:0] hold_interval;
    logic [5:0] base_gain;
  } acr_ctrl_t;

  typedef struct packed {
    logic i_scl;
    logic i_sda;
  } acr_pins_t;
endpackage

/* File: tb/acr_bank_props.sv */
`timescale 1ns/100ps
`include "acr_defs.svh"
module acr_bank_props (
  input wire logic               i_core_clk,
  input wire logic               i_srst,
  input wire logic               i_ce,
  input wire acr_pkg::acr_pins_t i_pins,
  input wire logic               i_short,
  input wire logic               i_overtemp,
  input wire logic               o_sda_oe_n,
  input wire acr_pkg::acr_ctrl_t o_ctrl
);
  import acr_pkg::*;
  localparam int RETRY = `ACR_RETRY_CYC;
  logic [15:0] quiet_cnt;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst || !i_ce);
  // Cycles spent in low duty with the short gone
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !o_ctrl.low_duty || i_short) begin
      quiet_cnt <= 16'h0;
    end else if (i_ce) begin
      quiet_cnt <= quiet_cnt + 16'h1;
    end
  end
  reset_out_a: assert property (disable iff (1'b0) i_srst && i_ce |=> o_ctrl == '0 && o_sda_oe_n)
    else $error("outputs not cleared in reset");
  defaults_a: assert property ($fell(i_srst) |-> ##[1:2] o_ctrl.attack_interval == 6'h05
    && o_ctrl.base_gain == 6'h06 && o_ctrl.amp_on && o_ctrl.gate_active) else $error("bad defaults");
  short_enter_a: assert property (i_short |-> ##[1:3] o_ctrl.low_duty && !o_ctrl.amp_on)
    else $error("short not handled");
  short_hold_a: assert property (o_ctrl.low_duty && i_short |=> o_ctrl.low_duty)
    else $error("left low duty during short");
  retry_max_a: assert property (quiet_cnt <= RETRY + 16)
    else $error("retry too late");
  retry_min_a: assert property ($fell(o_ctrl.low_duty) |-> quiet_cnt >= RETRY - 16)
    else $error("retry too early");
  overtemp_amp_a: assert property (i_overtemp [*3] |-> !o_ctrl.amp_on)
    else $error("amp on while hot");
  ratio_gate_a: assert property (o_ctrl.ratio == 2'b00 |-> !o_ctrl.gate_active)
    else $error("gate active at 1:1");
  scl_stable_a: assert property (i_pins.i_scl [*5] |-> $stable(o_sda_oe_n))
    else $error("sda moved while scl high");
  ce_freeze_a: assert property (disable iff (i_srst) !i_ce |=> $stable(o_ctrl) && $stable(o_sda_oe_n))
    else $error("state moved while frozen");
endmodule
bind acr_bank acr_bank_props acr_bank_props_i (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_ce(i_ce),
  .i_pins(i_pins), .i_short(i_short), .i_overtemp(i_overtemp), .o_sda_oe_n(o_sda_oe_n), .o_ctrl(o_ctrl));

/* File: tb/acr_host.sv */
`timescale 1ns/100ps
module acr_host (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl = 1'b1,
  output logic      o_sda = 1'b1
);
  task automatic w(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic cond(input logic a);
    o_scl = 1'b0;
    w(2);
    o_sda = a;
    w(3);
    o_scl = 1'b1;
    w(3);
    o_sda = !a;
    w(3);
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_scl = 1'b0;
    w(2);
    o_sda = b;
    w(3);
    o_scl = 1'b1;
    w(3);
    r = i_sda;
    w(2);
  endtask
  task automatic xfer(input logic [7:0] v, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(v[i], q[i]);
    bit_io(ai, ao);
  endtask
endmodule

/* File: tb/test_amp_control_register_bank.sv */
`timescale 1ns/100ps
module test_amp_control_register_bank;
  import acr_pkg::*;
  logic       i_core_clk;
  logic       i_srst;
  logic       i_ce;
  logic [7:0] q0;
  logic       a0;
  int         t0;
  logic       i_short;
  logic       i_overtemp;
  logic       scl;
  logic       sda_m;
  logic       o_sda_oe_n;
  acr_ctrl_t  o_ctrl;
  acr_pins_t  pins;
  int         fails;
  int         checks;
  int         cyc;
  logic [7:0] m [8];
  logic [7:0] d [$];
  assign pins = {scl, sda_m & o_sda_oe_n};
  acr_bank acr_bank_i (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_ce(i_ce), .i_pins(pins), .i_short(i_short),
    .i_overtemp(i_overtemp), .o_sda_oe_n(o_sda_oe_n), .o_ctrl(o_ctrl));
  acr_host acr_host_i (.i_core_clk(i_core_clk), .i_sda(pins.i_sda), .o_scl(scl), .o_sda(sda_m));
  task automatic final_report();
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic void put(input int p, input logic [7:0] v);
    case (p)
      1: m[1] = (v & 8'h6d) | 8'h82;
      2, 3, 4, 5: m[p] = v & 8'h3f;
      6: m[6] = v;
      7: m[7] = v & 8'hf3;
      default: ;
    endcase
  endfunction
  task automatic wr(input logic [7:0] p);
    logic [7:0] q;
    logic       a;
    acr_host_i.cond(1'b1);
    acr_host_i.xfer(8'hb0, 1'b1, q, a);
    chk({7'h0, a}, 8'h0);
    acr_host_i.xfer(p, 1'b1, q, a);
    chk({7'h0, a}, 8'h0);
    foreach (d[i]) begin
      acr_host_i.xfer(d[i], 1'b1, q, a);
      chk({7'h0, a}, 8'h0);
      put(p + i, d[i]);
    end
    acr_host_i.cond(1'b0);
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] q;
    logic       a;
    acr_host_i.cond(1'b1);
    acr_host_i.xfer(8'hb0, 1'b1, q, a);
    chk({7'h0, a}, 8'h0);
    acr_host_i.xfer(p, 1'b1, q, a);
    chk({7'h0, a}, 8'h0);
    acr_host_i.cond(1'b1);
    acr_host_i.xfer(8'hb1, 1'b1, q, a);
    chk({7'h0, a}, 8'h0);
    for (int i = 0; i < n; i++) begin
      acr_host_i.xfer(8'hff, i == n - 1, q, a);
      if (p + i inside {[1:7]}) chk(q, m[p + i]);
    end
    acr_host_i.cond(1'b0);
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 70000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    i_srst = 1'b1;
    i_ce = 1'b1;
    i_short = 1'b0;
    i_overtemp = 1'b0;
    void'($urandom(32'h75ee));
    m = '{8'h00, 8'hc3, 8'h05, 8'h0b, 8'h00, 8'h06, 8'h3a, 8'hc2};
    repeat (6) @(negedge i_core_clk);
    i_srst = 1'b0;
    repeat (6) @(negedge i_core_clk);
    rd(8'h00, 8);
    acr_host_i.cond(1'b1);
    acr_host_i.xfer(8'hb2, 1'b1, q0, a0);
    chk({7'h0, a0}, 8'h1);
    acr_host_i.cond(1'b0);
    for (int k = 0; k < 4; k++) begin
      d = {};
      repeat (6) d.push_back(8'($urandom));
      wr(8'h02);
      rd(8'h02, 6);
      chk({2'h0, o_ctrl.attack_interval}, m[2]);
      chk({2'h0, o_ctrl.release_interval}, m[3]);
      chk({2'h0, o_ctrl.hold_interval}, m[4]);
      chk({2'h0, o_ctrl.base_gain}, m[5]);
      chk({o_ctrl.limiter_off, o_ctrl.gate_thresh, o_ctrl.limit_level}, m[6]);
      chk({o_ctrl.max_gain, 2'h0, o_ctrl.ratio}, m[7]);
      d = {8'($urandom) & 8'h61};
      wr(8'h01);
      rd(8'h01, 1);
      chk({7'h0, o_ctrl.powered}, {7'h0, !m[1][5]});
      chk({7'h0, o_ctrl.gate_active}, {7'h0, m[1][0] && m[7][1:0] != 2'b00});
      chk({7'h0, o_ctrl.amp_on}, {7'h0, m[1][6] && !m[1][5]});
    end
    d = {8'h41};
    wr(8'h01);
    d = {8'h08, 8'h0d, 8'h0a, 8'h06, 8'h1a, 8'hf0};
    wr(8'h02);
    rd(8'h01, 7);
    chk({7'h0, o_ctrl.gate_active}, 8'h0);
    chk({o_ctrl.max_gain, 2'h0, o_ctrl.ratio}, m[7]);
    d = {8'hc2};
    wr(8'h07);
    chk({7'h0, o_ctrl.gate_active}, 8'h1);
    i_short = 1'b1;
    repeat (4) @(negedge i_core_clk);
    chk({7'h0, o_ctrl.low_duty}, 8'h1);
    repeat (14000) @(negedge i_core_clk);
    chk({7'h0, o_ctrl.low_duty}, 8'h1);
    chk({7'h0, o_ctrl.amp_on}, 8'h0);
    i_short = 1'b0;
    m[1][3] = 1'b1;
    t0 = cyc;
    while (o_ctrl.low_duty !== 1'b0 && cyc - t0 < 15000) @(negedge i_core_clk);
    chk({7'h0, o_ctrl.low_duty}, 8'h0);
    chk({7'h0, cyc - t0 >= 110000 / 8 && cyc - t0 <= 110000 / 8 + 10}, 8'h1);
    chk({7'h0, o_ctrl.amp_on}, 8'h1);
    rd(8'h01, 1);
    d = {m[1] & 8'hf7};
    wr(8'h01);
    rd(8'h01, 1);
    i_overtemp = 1'b1;
    repeat (3) @(negedge i_core_clk);
    i_overtemp = 1'b0;
    rd(8'h01, 1);
    i_overtemp = 1'b1;
    repeat (12) @(negedge i_core_clk);
    chk({7'h0, o_ctrl.amp_on}, 8'h0);
    i_overtemp = 1'b0;
    m[1][2] = 1'b1;
    rd(8'h01, 1);
    d = {m[1] & 8'hfb};
    wr(8'h01);
    rd(8'h01, 1);
    chk({7'h0, o_ctrl.amp_on}, 8'h1);
    i_ce = 1'b0;
    i_short = 1'b1;
    i_overtemp = 1'b1;
    repeat (12) @(negedge i_core_clk);
    chk({7'h0, o_ctrl.low_duty}, 8'h0);
    chk({7'h0, o_ctrl.amp_on}, 8'h1);
    i_short = 1'b0;
    i_overtemp = 1'b0;
    @(negedge i_core_clk);
    i_ce = 1'b1;
    rd(8'h01, 1);
    i_srst = 1'b1;
    repeat (3) @(negedge i_core_clk);
    i_srst = 1'b0;
    m = '{8'h00, 8'hc3, 8'h05, 8'h0b, 8'h00, 8'h06, 8'h3a, 8'hc2};
    repeat (6) @(negedge i_core_clk);
    rd(8'h01, 7);
    chk({7'h0, o_ctrl.amp_on && o_ctrl.powered && o_ctrl.gate_active}, 8'h1);
    final_report();
  end
endmodule
